// [core/pid_periodic_interrupt_divider.v]
// periodic tick generator with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "pid_defines.vh"
module pid_periodic_interrupt_divider #(
  parameter [19:0] DEC_PRESCALE = 20'h003e8
) (
  input  wire        i_clock,
  input  wire        i_arst_n,
  input  wire        i_oscillator_up_status,
  input  wire [3:0]  i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [3:0]  i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  output reg         o_periodic_tick_interrupt
);
  // ****************************************************************
  // reset release and pin synchroniser
  // ****************************************************************
  reg  [1:0]  rst_sync_reg;
  wire        rst_n = rst_sync_reg[1];
  reg         osc_meta_reg;
  reg         osc_sync_reg;
  // reset deasserts through two flops so release is clean
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  // oscillator status comes from another domain
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
    end else begin
      osc_meta_reg <= i_oscillator_up_status;
      osc_sync_reg <= osc_meta_reg;
    end
  end
  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [7:0]  periodic_tick_rate_control_reg;
  reg         tick_clock_source_select_reg;
  reg         status_reg;
  reg         mask_reg;
  reg         osc_prev_reg;
  reg  [3:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg         aw_held;
  reg         w_held;
  wire        wr_fire = o_awready == 1'b0 && o_wready == 1'b0 &&
                        aw_held && w_held && !o_bvalid;
  wire        wr_ctrl = wr_fire && awaddr_reg == `PID_ADDR_CTRL &&
                        wstrb_reg[0];
  wire        wr_src  = wr_fire && awaddr_reg == `PID_ADDR_SRC &&
                        wstrb_reg[0];
  wire        src_change = wr_src &&
                           wdata_reg[0] != tick_clock_source_select_reg;
  wire        osc_lost = osc_prev_reg && !osc_sync_reg;
  wire        restart = wr_ctrl || src_change || osc_lost;
  wire        rd_fire = i_arvalid && o_arready;
  wire        rd_status = rd_fire && i_araddr == `PID_ADDR_STATUS;
  wire        tick;
  // ****************************************************************
  // divider
  // ****************************************************************
  wire [2:0]  pre = periodic_tick_rate_control_reg[`PID_PRE_HI:`PID_PRE_LO];
  wire [3:0]  modsel =
    periodic_tick_rate_control_reg[`PID_MOD_HI:`PID_MOD_LO];
  wire        dec_mode = periodic_tick_rate_control_reg[`PID_BIT_DEC];
  wire        running = pre != `PID_PRE_OFF && osc_sync_reg;
  reg  [16:0] pre_cnt_reg;
  reg  [3:0]  mod_cnt_reg;
  // last prescaler count of a stage: 2^(9+code)-1 binary, DEC_PRESCALE-1 decimal
  function [16:0] pre_last;
    input [2:0] code;
    input       dec;
    begin
      if (dec) begin
        pre_last = DEC_PRESCALE[16:0] - 17'h00001;
      end else begin
        pre_last = (17'h00001 << ({2'h0, code} + `PID_PRE_BASE))
                   - 17'h00001;
      end
    end
  endfunction
  wire        pre_wrap = pre_cnt_reg == pre_last(pre, dec_mode);
  assign tick = running && pre_wrap && mod_cnt_reg == modsel;
  // decimal table is not provided, so decimal uses one fixed stage length
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_reg <= 17'h00000;
      mod_cnt_reg <= 4'h0;
    end else if (restart || !running) begin
      pre_cnt_reg <= 17'h00000;
      mod_cnt_reg <= 4'h0;
    end else if (pre_wrap) begin
      pre_cnt_reg <= 17'h00000;
      mod_cnt_reg <= tick ? 4'h0 : mod_cnt_reg + 4'h1;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 17'h00001;
    end
  end
  // ****************************************************************
  // control, status and interrupt
  // ****************************************************************
  // set wins over the clear-on-read so no tick is lost
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      periodic_tick_rate_control_reg <= `PID_CTRL_RST;
      tick_clock_source_select_reg   <= 1'b0;
      status_reg                     <= 1'b0;
      mask_reg                       <= 1'b0;
      osc_prev_reg                   <= 1'b0;
      o_periodic_tick_interrupt      <= 1'b0;
    end else begin
      osc_prev_reg <= osc_sync_reg;
      if (wr_ctrl) begin
        periodic_tick_rate_control_reg <= wdata_reg[7:0];
      end
      if (wr_src) begin
        tick_clock_source_select_reg <= wdata_reg[0];
      end
      if (wr_fire && awaddr_reg == `PID_ADDR_MASK && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[0];
      end
      if (tick) begin
        status_reg <= 1'b1;
      end else if (rd_status) begin
        status_reg <= 1'b0;
      end
      o_periodic_tick_interrupt <= (status_reg || tick) && mask_reg;
    end
  end
  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  // address and data are caught separately, then committed together
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_awready  <= 1'b1;
      o_wready   <= 1'b1;
      aw_held    <= 1'b0;
      w_held     <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
      o_bvalid   <= 1'b0;
      o_bresp    <= `PID_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        awaddr_reg <= i_awaddr;
        aw_held    <= 1'b1;
        o_awready  <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
        w_held    <= 1'b1;
        o_wready  <= 1'b0;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= (awaddr_reg[1:0] != 2'h0) ? `PID_RESP_SLVERR :
                    `PID_RESP_OKAY;
        aw_held  <= 1'b0;
        w_held   <= 1'b0;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end
  // read: one outstanding, answer one cycle after address is taken
  always @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= `PID_RESP_OKAY;
    end else if (rd_fire) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= `PID_RESP_OKAY;
      case (i_araddr)
        `PID_ADDR_CTRL: begin
          o_rdata <= {24'h000000, periodic_tick_rate_control_reg};
        end
        `PID_ADDR_STATUS: begin
          o_rdata <= {31'h00000000, status_reg};
        end
        `PID_ADDR_MASK: begin
          o_rdata <= {31'h00000000, mask_reg};
        end
        `PID_ADDR_SRC: begin
          o_rdata <= {30'h00000000, osc_sync_reg,
                      tick_clock_source_select_reg};
        end
        default: begin
          o_rdata <= 32'h00000000;
          o_rresp <= `PID_RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [pkg/pid_defines.vh]
// constants for the periodic interrupt divider
// Overview of operation
// - any software write with byte lane 0 enabled to the tick rate control register restarts the time-out period.
// - a change of the clock source select or a loss of oscillator-up status restarts the period.
// - bit 7 picks the divider style, 0 binary and 1 decimal.
// - in binary style prescale code 000 is off and codes 1 to 7 select 2^10 to 2^16.
// - the modulus field gives an extra multiplier of its value plus one.
// - the binary period is the modulus multiplier times the power-of-two prescaler.
`ifndef PID_DEFINES_VH
`define PID_DEFINES_VH
// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define PID_ADDR_CTRL     4'h0
`define PID_ADDR_STATUS   4'h4
`define PID_ADDR_MASK     4'h8
`define PID_ADDR_SRC      4'hc
// ****************************************************************
// fields and reset values
// ****************************************************************
`define PID_BIT_DEC       7
`define PID_PRE_HI        6
`define PID_PRE_LO        4
`define PID_MOD_HI        3
`define PID_MOD_LO        0
`define PID_CTRL_RST      8'h00
`define PID_PRE_OFF       3'h0
`define PID_PRE_BASE      5'h09
`define PID_RESP_OKAY     2'h0
`define PID_RESP_SLVERR   2'h2
`endif

// [bench/pid_asserts.sv]
// port-level assertions for the periodic interrupt divider
`timescale 1ns/1ps
`default_nettype none
module pid_asserts (
  input wire logic        i_clock,
  input wire logic        i_arst_n,
  input wire logic        i_awvalid,
  input wire logic        i_wvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        i_rready,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid,
  input wire logic        o_periodic_tick_interrupt,
  input wire logic [1:0]  o_bresp,
  input wire logic [1:0]  o_rresp,
  input wire logic [31:0] o_rdata
);
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // handshakes that start a read or a paired write
  sequence ar_take; i_arvalid && o_arready; endsequence
  sequence aw_w_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  read_answer_a: assert property (ar_take |=> o_rvalid)
    else $error("read answer late");
  write_answer_a: assert property (aw_w_take |=> !o_bvalid ##1 o_bvalid)
    else $error("write answer not two cycles after take");
  b_hold_a: assert property (o_bvalid && !i_bready |=>
                             o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (o_rvalid && !i_rready |=>
                             o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  read_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read address open during answer");
  write_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write channels open during answer");
  b_done_a: assert property (o_bvalid && i_bready |=> !o_bvalid)
    else $error("write response repeated");
  r_done_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read answer repeated");
  // the flag is sticky: the line may only drop after a read or a write
  irq_sticky_a: assert property ($fell(o_periodic_tick_interrupt) |->
    o_bvalid || o_rvalid || $past(o_rvalid) || $past(i_arvalid) ||
    $past(i_arvalid, 2))
    else $error("interrupt dropped without access");
endmodule
bind pid_periodic_interrupt_divider pid_asserts u_pid_asserts (.i_clock, .i_arst_n,
  .i_awvalid, .i_wvalid, .i_bready, .i_arvalid, .i_rready, .o_awready, .o_wready,
  .o_bvalid, .o_arready, .o_rvalid, .o_periodic_tick_interrupt, .o_bresp, .o_rresp,
  .o_rdata);
`default_nettype wire

// [bench/periodic_interrupt_divider_test.sv]
// self-checking bench for the periodic interrupt divider
`timescale 1ns/1ps
`default_nettype none
`include "pid_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module periodic_interrupt_divider_test;
  localparam int DEC = 100; // short decimal stage keeps the run brief
  logic clk = 0, rst_n = 0, osc = 1, awv = 0, wv = 0, bready = 0, arv = 0;
  logic rready = 0, s = 0, dec;
  logic [3:0] awaddr = 0, araddr = 0, m, wstrb = 4'hf;
  logic [2:0] pre;
  logic [31:0] wdata = 0, d, rdata;
  logic [1:0] r, bresp, rresp;
  wire awready, wready, bvalid, arready, rvalid, irq;
  int n_fail = 0, total_checks = 0, n, q, e;
  time t0;
  pid_periodic_interrupt_divider #(.DEC_PRESCALE(20'h00064)) u_pid_periodic_interrupt_divider (
    .i_clock(clk), .i_arst_n(rst_n), .i_oscillator_up_status(osc),
    .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wv), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_periodic_tick_interrupt(irq));
  always #5 clk = ~clk;
  // ****************************************************************
  // bus and wait tasks; every wait is bounded
  // ****************************************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [1:0] er);
    int k;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, v}; awv <= 1; wv <= 1; bready <= 1;
    for (k = 0; k < 99 && bvalid !== 1; k++) begin
      @(posedge clk);
      if (awready) awv <= 0;
      if (wready) wv <= 0;
    end
    if (bvalid !== 1) begin n_fail++; tally_and_finish; end
    bready <= 0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [3:0] a);
    int k;
    @(posedge clk);
    araddr <= a; arv <= 1; rready <= 1;
    for (k = 0; k < 99 && rvalid !== 1; k++) begin
      @(posedge clk);
      if (arready) arv <= 0;
    end
    if (rvalid !== 1) begin n_fail++; tally_and_finish; end
    d = rdata; r = rresp; rready <= 0;
  endtask
  task automatic wait_hi;
    int k;
    logic p;
    p = irq;
    // a fresh rising edge only, so a line left high is not taken as a tick
    for (k = 0; k < 30000; k++) begin
      @(posedge clk);
      if (irq === 1 && p !== 1) break;
      p = irq;
    end
    if (k == 30000) begin n_fail++; tally_and_finish; end
  endtask
  initial begin
    d = $urandom(32'ha93e25cc);
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd(`PID_ADDR_CTRL); `CHK(d, 32'h0)
    rd(4'h2); `CHK(r, `PID_RESP_SLVERR)
    wr(4'h1, 8'h15, `PID_RESP_SLVERR);
    rd(`PID_ADDR_CTRL); `CHK(d, 32'h0)
    // a write with byte lane 0 off must leave the control untouched
    wstrb <= 4'h0;
    wr(`PID_ADDR_CTRL, 8'h15, `PID_RESP_OKAY);
    wstrb <= 4'hf;
    rd(`PID_ADDR_CTRL); `CHK(d, 32'h0)
    $display("bus test done");
    wr(`PID_ADDR_MASK, 8'h01, `PID_RESP_OKAY);
    // period model: binary (m+1)*2^(9+pre), decimal (m+1)*stage
    for (n = 0; n < 6; n++) begin
      dec = n > 3; pre = n / 2 % 2 + 1; m = $urandom_range(1, 0);
      e = dec ? (m + 1) * DEC : (m + 1) << (9 + pre);
      wr(`PID_ADDR_CTRL, {dec, pre, m}, `PID_RESP_OKAY);
      rd(`PID_ADDR_STATUS);
      wait_hi; t0 = $time;
      rd(`PID_ADDR_STATUS); `CHK(d, 32'h1)
      wait_hi; q = ($time - t0) / 10;
      `CHK(q, e)
      $display("period test %0d done", n);
    end
    // restart by control write, source toggle and oscillator loss
    wr(`PID_ADDR_CTRL, 8'h10, `PID_RESP_OKAY);
    for (n = 0; n < 3; n++) begin
      rd(`PID_ADDR_STATUS);
      wait_hi; t0 = $time;
      rd(`PID_ADDR_STATUS);
      repeat (500) @(posedge clk);
      if (n == 0) wr(`PID_ADDR_CTRL, 8'h10, `PID_RESP_OKAY);
      else if (n == 1) begin s = ~s; wr(`PID_ADDR_SRC, {7'h0, s}, `PID_RESP_OKAY); end
      else begin osc <= 0; repeat (5) @(posedge clk); osc <= 1; end
      wait_hi; `CHK(($time - t0) / 10 > 1024, 1'b1)
      $display("restart test %0d done", n);
    end
    // prescale code zero stops ticks entirely
    // modulus zero, so a wrongly decoded off code would tick within 2100
    wr(`PID_ADDR_CTRL, 8'h00, `PID_RESP_OKAY);
    rd(`PID_ADDR_STATUS);
    repeat (2100) @(posedge clk);
    rd(`PID_ADDR_STATUS); `CHK(d, 32'h0)
    $display("off test done");
    // masked tick stays sticky but silent, unmasking raises the line
    wr(`PID_ADDR_MASK, 8'h00, `PID_RESP_OKAY);
    wr(`PID_ADDR_CTRL, 8'h90, `PID_RESP_OKAY);
    repeat (250) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(`PID_ADDR_MASK, 8'h01, `PID_RESP_OKAY);
    @(posedge clk);
    `CHK(irq, 1'b1)
    rd(`PID_ADDR_STATUS); `CHK(d, 32'h1)
    $display("mask test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
